// ===== verilog/pwm_pkg.sv
package pwm_pkg;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam int CNT_W = 16;
    localparam int NUM_CH = 2;
    localparam int CTRL_W = 5;
    localparam int CH_CTRL_W = 5;
    localparam int SIGN_BIT = 15;

    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_INIT = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_PERIOD = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_CH0_CTRL = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_CH0_VALUE = 8'h24;
    localparam logic [ADDR_W-1:0] OFS_CH1_CTRL = 8'h28;
    localparam logic [ADDR_W-1:0] OFS_CH1_VALUE = 8'h2C;

    localparam int CTRL_UDS = 0;
    localparam int CTRL_EFE = 1;
    localparam int CTRL_JOIN = 2;
    localparam int CTRL_DECE = 3;
    localparam int CTRL_RUN = 4;

    localparam int CH_ELSA = 0;
    localparam int CH_ELSB = 1;
    localparam int CH_MSA = 2;
    localparam int CH_MSB = 3;
    localparam int CH_IE = 4;

    localparam logic [1:0] ELS_OFF = 2'h0;
    localparam logic [1:0] ELS_TOGGLE = 2'h1;
    localparam logic [1:0] ELS_CLEAR = 2'h2;
    localparam logic [1:0] MS_COMPARE = 2'h1;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic HRESP_OKAY = 1'b0;

    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
endpackage

// ===== verilog/pwm_counter.sv
`timescale 1ns/1ps
module pwm_counter #(
    parameter int W = pwm_pkg::CNT_W
) (
    input  wire logic         clock,
    input  wire logic         sys_rst,
    input  wire logic         run,
    input  wire logic         up_down,
    input  wire logic         free_ok,
    input  wire logic [W-1:0] init_value,
    input  wire logic [W-1:0] period_end_value,
    output logic      [W-1:0] count,
    output logic      [W-1:0] nxt,
    output logic              down,
    output logic              nxt_down,
    output logic              wrap
);
    logic [W-1:0] limit;

    // Next count is exported so that channel events line up with the count change.
    always_comb begin
        limit = (free_ok && period_end_value == '0) ? '1 : period_end_value;
        nxt = count;
        nxt_down = down;
        wrap = 1'b0;
        if (run) begin
            if (!up_down) begin
                nxt_down = 1'b0;
                if (count == limit) begin
                    nxt = init_value;
                    wrap = 1'b1;
                end else begin
                    nxt = W'(count + 1'b1);
                end
            end else if (!down) begin
                if (count >= period_end_value) begin
                    nxt_down = 1'b1;
                    nxt = W'(count - 1'b1);
                end else begin
                    nxt = W'(count + 1'b1);
                end
            end else begin
                if (count <= init_value) begin
                    nxt_down = 1'b0;
                    nxt = W'(count + 1'b1);
                end else begin
                    nxt = W'(count - 1'b1);
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            count <= '0;
            down <= 1'b0;
        end else begin
            count <= nxt;
            down <= nxt_down;
        end
    end
endmodule // pwm_counter

// ===== verilog/pwm_channels.sv
`timescale 1ns/1ps
module pwm_channels (
    input  wire logic                        clock,
    input  wire logic                        sys_rst,
    input  wire logic                        hsel,
    input  wire logic [pwm_pkg::DATA_W-1:0]  haddr,
    input  wire logic [1:0]                  htrans,
    input  wire logic                        hwrite,
    input  wire logic [2:0]                  hsize,
    input  wire logic [pwm_pkg::DATA_W-1:0]  hwdata,
    input  wire logic                        hready,
    output logic                             hreadyout,
    output logic      [pwm_pkg::DATA_W-1:0]  hrdata,
    output logic                             hresp,
    output logic      [pwm_pkg::NUM_CH-1:0]  ch_out,
    output logic      [pwm_pkg::NUM_CH-1:0]  ch_oe,
    output logic      [pwm_pkg::NUM_CH-1:0]  ch_irq
);
    import pwm_pkg::*;

    logic [CTRL_W-1:0]    ctrl;
    logic [CNT_W-1:0]     init_value;
    logic [CNT_W-1:0]     period_end_value;
    logic [CH_CTRL_W-1:0] ch_ctrl [NUM_CH];
    logic [CNT_W-1:0]     channel_value [NUM_CH];
    logic [NUM_CH-1:0]    channel_flag;
    logic [NUM_CH-1:0]    wave;
    logic [NUM_CH-1:0]    next_wave;
    logic [NUM_CH-1:0]    next_flag;
    logic [NUM_CH-1:0]    flag_set;
    logic [NUM_CH-1:0]    flag_clr;
    logic [NUM_CH-1:0]    match;
    logic [NUM_CH-1:0]    pol;
    logic [NUM_CH-1:0]    mode_oc;
    logic [NUM_CH-1:0]    mode_edge_aligned_pwm;
    logic [NUM_CH-1:0]    mode_center_aligned_pwm;
    logic [NUM_CH-1:0]    e_zero;
    logic [NUM_CH-1:0]    e_full;
    logic [NUM_CH-1:0]    c_zero;
    logic [NUM_CH-1:0]    c_full;
    logic [1:0]           els [NUM_CH];
    logic                 mode_comb;
    logic                 run;
    logic                 up_down_select;
    logic [CNT_W-1:0]     count;
    logic [CNT_W-1:0]     nxt;
    logic                 down;
    logic                 nxt_down;
    logic                 wrap;
    logic                 start;
    logic                 accept;
    logic                 wr_pend;
    logic                 rd_pend;
    logic [ADDR_W-1:0]    addr_q;
    logic [DATA_W-1:0]    rd_mux;

    assign run = ctrl[CTRL_RUN];
    assign up_down_select = ctrl[CTRL_UDS];

    pwm_counter #(
        .W(CNT_W)
    ) u_counter (
        .clock            (clock),
        .sys_rst          (sys_rst),
        .run              (run),
        .up_down          (up_down_select),
        .free_ok          (!ctrl[CTRL_EFE]),
        .init_value       (init_value),
        .period_end_value (period_end_value),
        .count            (count),
        .nxt              (nxt),
        .down             (down),
        .nxt_down         (nxt_down),
        .wrap             (wrap)
    );

    // Mode decode and per-channel match qualification.
    assign mode_comb = ctrl[CTRL_EFE] && !ctrl[CTRL_DECE] && ctrl[CTRL_JOIN]
                       && !up_down_select;
    assign start = run && nxt == init_value;

    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            els[i] = {ch_ctrl[i][CH_ELSB], ch_ctrl[i][CH_ELSA]};
            mode_oc[i] = !ctrl[CTRL_DECE] && !ctrl[CTRL_JOIN] && !up_down_select
                         && {ch_ctrl[i][CH_MSB], ch_ctrl[i][CH_MSA]} == MS_COMPARE;
            mode_edge_aligned_pwm[i] = !ctrl[CTRL_DECE] && !ctrl[CTRL_JOIN] && !up_down_select
                           && ch_ctrl[i][CH_MSB];
            mode_center_aligned_pwm[i] = !ctrl[CTRL_DECE] && !ctrl[CTRL_JOIN] && up_down_select;
            match[i] = run && nxt == channel_value[i];
            e_zero[i] = channel_value[i] == CNT_ZERO;
            e_full[i] = channel_value[i] > period_end_value;
            c_zero[i] = e_zero[i] || channel_value[i][SIGN_BIT];
            c_full[i] = !channel_value[i][SIGN_BIT] && period_end_value != CNT_ZERO
                        && channel_value[i] >= period_end_value;
            flag_set[i] = match[i] && (mode_oc[i] || mode_comb
                          || (mode_edge_aligned_pwm[i] && !e_zero[i] && !e_full[i])
                          || (mode_center_aligned_pwm[i] && !c_zero[i] && !c_full[i]));
        end
    end

    // The level held in wave is the active-high form; pol turns it for X:1 in every mode but output compare, taking channel 0's select for both in combine.
    always_comb begin
        next_wave = wave;
        for (int i = 0; i < NUM_CH; i++) begin
            pol[i] = mode_oc[i] ? 1'b0 : els[mode_comb ? 0 : i][0];
            if (mode_comb) begin
                if (i == 0) begin
                    if (match[1]) begin
                        next_wave[0] = 1'b0;
                    end else if (match[0]) begin
                        next_wave[0] = 1'b1;
                    end else if (start) begin
                        next_wave[0] = 1'b0;
                    end
                end else begin
                    next_wave[i] = next_wave[0];
                end
            end else if (mode_edge_aligned_pwm[i]) begin
                if (e_zero[i]) begin
                    next_wave[i] = 1'b0;
                end else if (e_full[i]) begin
                    next_wave[i] = 1'b1;
                end else if (match[i]) begin
                    next_wave[i] = 1'b0;
                end else if (wrap) begin
                    next_wave[i] = 1'b1;
                end
            end else if (mode_center_aligned_pwm[i]) begin
                if (c_zero[i]) begin
                    next_wave[i] = 1'b0;
                end else if (c_full[i]) begin
                    next_wave[i] = 1'b1;
                end else if (match[i]) begin
                    next_wave[i] = nxt_down;
                end
            end else if (mode_oc[i] && match[i]) begin
                unique case (els[i])
                    ELS_OFF:    next_wave[i] = wave[i];
                    ELS_TOGGLE: next_wave[i] = !wave[i];
                    ELS_CLEAR:  next_wave[i] = 1'b0;
                    default:    next_wave[i] = 1'b1;
                endcase
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wave <= '0;
            ch_out <= '0;
            ch_oe <= '0;
        end else begin
            wave <= next_wave;
            ch_out <= next_wave ^ pol;
            for (int i = 0; i < NUM_CH; i++) begin
                ch_oe[i] <= els[i] != ELS_OFF;
            end
        end
    end

    // Flags: a match in the clearing cycle wins over the clear.
    assign flag_clr = (wr_pend && addr_q == OFS_STATUS) ? hwdata[NUM_CH-1:0] : '0;
    assign next_flag = (channel_flag & ~flag_clr) | flag_set;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            channel_flag <= '0;
            ch_irq <= '0;
        end else begin
            channel_flag <= next_flag;
            for (int i = 0; i < NUM_CH; i++) begin
                ch_irq[i] <= next_flag[i] && ch_ctrl[i][CH_IE];
            end
        end
    end

    // Bus slave: writes complete with no wait, reads insert one wait state.
    assign accept = hsel && hready && htrans == HTRANS_NONSEQ;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            addr_q <= '0;
            hreadyout <= 1'b1;
            hresp <= HRESP_OKAY;
            hrdata <= '0;
        end else begin
            hresp <= HRESP_OKAY;
            wr_pend <= accept && hwrite && hsize == HSIZE_WORD;
            rd_pend <= accept && !hwrite;
            hreadyout <= !(accept && !hwrite);
            if (accept) begin
                addr_q <= haddr[ADDR_W-1:0];
            end
            if (rd_pend) begin
                hrdata <= rd_mux;
            end
        end
    end

    always_comb begin
        unique case (addr_q)
            OFS_CTRL:      rd_mux = DATA_W'(ctrl);
            OFS_INIT:      rd_mux = DATA_W'(init_value);
            OFS_PERIOD:    rd_mux = DATA_W'(period_end_value);
            OFS_COUNT:     rd_mux = DATA_W'({down, count});
            OFS_STATUS:    rd_mux = DATA_W'({ch_oe, ch_out, channel_flag});
            OFS_CH0_CTRL:  rd_mux = DATA_W'(ch_ctrl[0]);
            OFS_CH0_VALUE: rd_mux = DATA_W'(channel_value[0]);
            OFS_CH1_CTRL:  rd_mux = DATA_W'(ch_ctrl[1]);
            OFS_CH1_VALUE: rd_mux = DATA_W'(channel_value[1]);
            default:       rd_mux = '0;
        endcase
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ctrl <= '0;
            init_value <= '0;
            period_end_value <= '0;
            for (int i = 0; i < NUM_CH; i++) begin
                ch_ctrl[i] <= '0;
                channel_value[i] <= '0;
            end
        end else if (wr_pend) begin
            unique case (addr_q)
                OFS_CTRL:      ctrl <= hwdata[CTRL_W-1:0];
                OFS_INIT:      init_value <= hwdata[CNT_W-1:0];
                OFS_PERIOD:    period_end_value <= hwdata[CNT_W-1:0];
                OFS_CH0_CTRL:  ch_ctrl[0] <= hwdata[CH_CTRL_W-1:0];
                OFS_CH0_VALUE: channel_value[0] <= hwdata[CNT_W-1:0];
                OFS_CH1_CTRL:  ch_ctrl[1] <= hwdata[CH_CTRL_W-1:0];
                OFS_CH1_VALUE: channel_value[1] <= hwdata[CNT_W-1:0];
                default:       ;
            endcase
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);

    sequence s_low0;
        ##1 ch_out[0] == 1'b0;
    endsequence

    sequence s_high0;
        ##1 ch_out[0] == 1'b1;
    endsequence

    AST_RELEASE_FLAGS: assert property (
        (mode_edge_aligned_pwm[0] || mode_center_aligned_pwm[0] || mode_oc[0]) && els[0] == ELS_OFF && flag_set[0]
        |=> !ch_oe[0] && channel_flag[0])
        else $error("released channel lost its flag or drove the pin");

    AST_EDGE_ALIGNED_PWM_FALL: assert property (
        mode_edge_aligned_pwm[0] && els[0] == ELS_CLEAR && match[0] && !e_zero[0] && !e_full[0]
        |-> s_low0)
        else $error("edge-aligned output not low after match");

    AST_EDGE_ALIGNED_PWM_RISE: assert property (
        mode_edge_aligned_pwm[0] && els[0] == ELS_CLEAR && wrap && !match[0] && !e_zero[0] && !e_full[0]
        |-> s_high0)
        else $error("edge-aligned output not high after overflow");

    AST_EDGE_ALIGNED_PWM_ZERO: assert property (
        mode_edge_aligned_pwm[0] && e_zero[0] && els[0] == ELS_CLEAR
        |-> !flag_set[0] ##0 s_low0)
        else $error("zero duty edge-aligned misbehaves");

    AST_EDGE_ALIGNED_PWM_FULL: assert property (
        mode_edge_aligned_pwm[0] && !e_zero[0] && e_full[0] && els[0] == ELS_CLEAR
        |-> !flag_set[0] ##0 s_high0)
        else $error("full duty edge-aligned misbehaves");

    AST_CENTER_ALIGNED_PWM_TURN: assert property (
        run && up_down_select && !down && count >= period_end_value
        |=> down && count == CNT_W'($past(count) - 1'b1))
        else $error("up-down counter did not turn at period end");

    AST_CENTER_ALIGNED_PWM_NEG: assert property (
        mode_center_aligned_pwm[0] && channel_value[0][SIGN_BIT] && els[0] == ELS_CLEAR
        |-> !flag_set[0] ##0 s_low0)
        else $error("negative center-aligned value not at zero duty");

    AST_CENTER_ALIGNED_PWM_DOWN: assert property (
        mode_center_aligned_pwm[0] && els[0] == ELS_CLEAR && match[0] && nxt_down && !c_zero[0] && !c_full[0]
        |-> flag_set[0] ##0 s_high0)
        else $error("center-aligned down match did not raise output");

    AST_COMB_ODD: assert property (
        mode_comb && els[0] == ELS_CLEAR && match[1] |-> s_low0)
        else $error("combine output not low after odd match");

    AST_FLAG_HOLD: assert property (
        channel_flag[0] && !flag_clr[0] |=> channel_flag[0])
        else $error("channel flag dropped without a clear");

    AST_IRQ: assert property (
        $rose(channel_flag[0]) && ch_ctrl[0][CH_IE] && $stable(ch_ctrl[0])
        |-> ch_irq[0])
        else $error("interrupt did not follow flag and enable");

    AST_EDGE_ALIGNED_PWM_FLAG: assert property (
        mode_edge_aligned_pwm[0] && match[0] && !e_zero[0] && !e_full[0]
        |=> channel_flag[0])
        else $error("edge-aligned match did not set the flag");

    AST_CENTER_ALIGNED_PWM_UP: assert property (
        mode_center_aligned_pwm[0] && els[0] == ELS_CLEAR && match[0] && !nxt_down && !c_zero[0] && !c_full[0]
        |-> flag_set[0] ##0 s_low0)
        else $error("center-aligned up match did not drop output");

    AST_COMB_EVEN: assert property (
        mode_comb && els[0] == ELS_CLEAR && match[0] && !match[1]
        |-> s_high0)
        else $error("combine output not high after even match");

    AST_COMB_PINS: assert property (
        mode_comb && els[1] == ELS_OFF && els[0] != ELS_OFF
        |=> !ch_oe[1] && ch_oe[0])
        else $error("combine pin release does not follow its own select");

    AST_COMB_FLAG: assert property (
        mode_comb && match[1]
        |=> channel_flag[1])
        else $error("combine odd match did not set the odd flag");
endmodule // pwm_channels

// ===== testbench/pwm_channels_tb_top.sv
`timescale 1ns/1ps
module pwm_channels_tb_top;
    import pwm_pkg::*;

    logic                clock;
    logic                sys_rst;
    logic                hsel;
    logic [DATA_W-1:0]   haddr;
    logic [1:0]          htrans;
    logic                hwrite;
    logic [2:0]          hsize;
    logic [DATA_W-1:0]   hwdata;
    wire logic           hready;
    logic                hreadyout;
    logic [DATA_W-1:0]   hrdata;
    logic                hresp;
    logic [NUM_CH-1:0]   ch_out;
    logic [NUM_CH-1:0]   ch_oe;
    logic [NUM_CH-1:0]   ch_irq;
    logic [DATA_W-1:0]   rd;
    int                  num_errors = 0;
    int                  checks = 0;

    assign hready = hreadyout;

    pwm_channels i_dut (
        .clock     (clock),
        .sys_rst   (sys_rst),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hready),
        .hreadyout (hreadyout),
        .hrdata    (hrdata),
        .hresp     (hresp),
        .ch_out    (ch_out),
        .ch_oe     (ch_oe),
        .ch_irq    (ch_irq)
    );

    task automatic tally_and_finish;
        if (num_errors == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_bits(input string name, input logic [1:0] exp, input logic [1:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic chk_cnt(input string name, input int exp, input int got);
        checks++;
        if (got != exp) begin
            num_errors++;
            $display("[FAIL] %s expected %0d seen %0d", name, exp, got);
        end
    endtask

    // Returns at the rising edge where hready was sampled high.
    task automatic wait_ready;
        int n;
        n = 0;
        @(posedge clock);
        while (hready !== 1'b1 && n < 16) begin
            n++;
            @(posedge clock);
        end
        if (hready !== 1'b1) begin
            num_errors++;
            $display("[FAIL] hready expected 1 seen %b", hready);
        end
    endtask

    task automatic ahb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        hsize <= HSIZE_WORD;
        wait_ready;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready;
        rd = hrdata;
        chk_bits("hresp", 2'h0, {1'b0, hresp});
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        ahb_xfer(1'b1, a, d);
    endtask

    task automatic rd_reg(input logic [7:0] a);
        ahb_xfer(1'b0, a, 32'h00000000);
    endtask

    // Stops the counter, loads a configuration, clears flags, restarts, lets it settle.
    task automatic setup(input logic [4:0] ctrl, input logic [15:0] per,
                         input logic [4:0] c0, input logic [15:0] v0,
                         input logic [4:0] c1, input logic [15:0] v1);
        wr_reg(OFS_CTRL, 32'h00000000);
        wr_reg(OFS_INIT, 32'h00000000);
        wr_reg(OFS_PERIOD, {16'h0000, per});
        wr_reg(OFS_CH0_CTRL, {27'h0000000, c0});
        wr_reg(OFS_CH0_VALUE, {16'h0000, v0});
        wr_reg(OFS_CH1_CTRL, {27'h0000000, c1});
        wr_reg(OFS_CH1_VALUE, {16'h0000, v1});
        wr_reg(OFS_STATUS, 32'h00000003);
        wr_reg(OFS_CTRL, {27'h0000000, ctrl} | 32'h00000010);
        repeat (24) @(posedge clock);
    endtask

    // High-time counts over whole periods do not depend on where the window starts.
    task automatic expect_run(input int cyc, input int e0, input int e1, input logic [1:0] eoe,
                              input logic [1:0] efl, input logic [1:0] eirq);
        int h0;
        int h1;
        h0 = 0;
        h1 = 0;
        repeat (cyc) begin
            @(posedge clock);
            if (ch_out[0] === 1'b1) h0++;
            if (ch_out[1] === 1'b1) h1++;
        end
        if (e0 >= 0) chk_cnt("ch0 high cycles", e0, h0);
        if (e1 >= 0) chk_cnt("ch1 high cycles", e1, h1);
        chk_bits("ch_oe", eoe, ch_oe);
        chk_bits("ch_irq", eirq, ch_irq);
        rd_reg(OFS_STATUS);
        chk_bits("channel flags", efl, rd[1:0]);
    endtask

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    initial begin
        repeat (20000) @(posedge clock);
        num_errors++;
        $display("[FAIL] watchdog expected done seen timeout");
        tally_and_finish;
    end

    initial begin
        sys_rst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h0;
        hwdata = 32'h00000000;
        repeat (4) @(posedge clock);
        sys_rst <= 1'b0;
        rd_reg(OFS_CTRL);
        chk_word("ctrl reset", 32'h00000000, rd);
        rd_reg(OFS_STATUS);
        chk_word("status reset", 32'h00000000, rd);
        rd_reg(OFS_COUNT);
        chk_word("count reset", 32'h00000000, rd);
        chk_bits("ch_oe reset", 2'h0, ch_oe);
        wr_reg(OFS_PERIOD, 32'hFFFF0004);
        rd_reg(OFS_PERIOD);
        chk_word("period readback", 32'h00000004, rd);
        wr_reg(8'h40, 32'hFFFFFFFF);
        rd_reg(8'h40);
        chk_word("unmapped read", 32'h00000000, rd);
        // Edge-aligned, period 5 counts: value 2 high 2, value 0 never high.
        setup(5'h00, 16'h0004, 5'h1A, 16'h0002, 5'h1A, 16'h0000);
        expect_run(20, 8, 0, 2'h3, 2'h1, 2'h1);
        wr_reg(OFS_CTRL, 32'h00000000);
        wr_reg(OFS_STATUS, 32'h00000003);
        rd_reg(OFS_STATUS);
        chk_bits("flags after clear", 2'h0, rd[1:0]);
        chk_bits("ch_irq after clear", 2'h0, ch_irq);
        // Value above period end on channel 0 with its interrupt off; channel 1 inverted.
        setup(5'h00, 16'h0004, 5'h0A, 16'h0005, 5'h19, 16'h0002);
        expect_run(20, 20, 12, 2'h3, 2'h2, 2'h2);
        // Edge-level 0:0 releases both pins yet still flags.
        setup(5'h00, 16'h0004, 5'h08, 16'h0002, 5'h18, 16'h0003);
        expect_run(20, -1, -1, 2'h0, 2'h3, 2'h2);
        // Center-aligned, period 8 counts: negative value never high, X:1 value 1 high 6.
        setup(5'h01, 16'h0004, 5'h12, 16'h8001, 5'h11, 16'h0001);
        expect_run(32, 0, 24, 2'h3, 2'h2, 2'h2);
        // Center-aligned value 1 high 2; value at period end is full duty, inverted by X:1.
        setup(5'h01, 16'h0004, 5'h02, 16'h0001, 5'h11, 16'h0004);
        expect_run(32, 8, 0, 2'h3, 2'h1, 2'h0);
        // Combine, period 10 counts, high from even match 2 to odd match 6.
        setup(5'h06, 16'h0009, 5'h12, 16'h0002, 5'h10, 16'h0006);
        expect_run(30, 12, -1, 2'h1, 2'h3, 2'h3);
        // Odd select bits must not shape the wave; even X:1 inverts it.
        setup(5'h06, 16'h0009, 5'h01, 16'h0002, 5'h02, 16'h0006);
        expect_run(30, 18, 18, 2'h3, 2'h3, 2'h0);
        wr_reg(OFS_CTRL, 32'h00000000);
        tally_and_finish;
    end
endmodule // pwm_channels_tb_top
